// *** common/fuse_security_pkg.sv ***
// Constants and carrier types for the program security and fuse control block.
// Assumes an 8-bit register view placed on a 32-bit classic Wishbone slave.
package fuse_security_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [15:0] FLASH_CONTROL_IDX        = 16'h00b2;
    localparam logic [15:0] FUSE_BURN_CONTROL_IDX    = 16'hffd1;
    localparam logic [15:0] FUSE_SETUP_CONTROL_IDX   = 16'hffd2;
    localparam logic [15:0] SECURITY_FUSE_STATUS_IDX = 16'hffd7;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int PROGRAM_WRITE_ENABLE_BIT = 0;
    localparam int MASS_ERASE_ENABLE_BIT    = 1;
    localparam int PROTECT_LOCK_BIT         = 6;
    localparam int LEVEL0_FUSE_BIT          = 0;
    localparam int LEVEL1_FUSE_BIT          = 1;
    localparam int REQUEST_PIN_LEVEL_BIT    = 5;
    localparam int FUSE_PROGRAM_ENABLE_BIT  = 7;

    // ------------------------------------------------------------------
    // Magic values and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] FUSE_SETUP_VALUE  = 8'h54;
    localparam logic [7:0] FUSE_BURN_VALUE   = 8'ha6;
    localparam logic [7:0] SELECT_LEVEL0     = 8'h81;
    localparam logic [7:0] SELECT_LEVEL1     = 8'h82;
    localparam logic [7:0] REG_RESET_VALUE   = 8'h00;
    localparam logic [31:0] UNMAPPED_READ    = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLOCK_HZ      = 25_000_000;
    localparam int BURN_TIME_US  = 500;
    localparam int BURN_CYCLES   = (BURN_TIME_US * (CLOCK_HZ / 1_000_000));

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_READ, OP_WRITE, OP_PAGE_ERASE, OP_MASS_ERASE, OP_CONTROL
    } flash_op_t;

    typedef struct packed {
        logic      valid;
        flash_op_t op;
        logic      page_zero;
    } flash_req_t;

endpackage

// *** rtl/program_security_fuse_control.sv ***
// Program and data protection: protect-lock bit, two fuse-backed security
// levels, fuse burn sequencer, flash write and mass-erase enables.
// Assumes one 25 MHz clock, a classic Wishbone master, an on-chip fuse sense
// and a flash controller that reports each byte written.
//
// Overview of operation
// - Protect-lock bit clears on reset, software may set it, zero writes ignored.
// - Level 0 takes effect only if protect-lock set and level-0 fuse blown.
// - Under level 0 the debug port may only perform bulk flash erase.
// - With protect-lock set, page-zero page erase is refused from both sources.
// - With protect-lock set, writes to page zero are suppressed from both sources.
// - A global flash erase also clears external data RAM, always.
// - Level 0 ends at any reset, which clears protect-lock, restoring debug control.
// - With protect-lock set, debug-port flash reads are refused.
// - Blown level-1 fuse disables the debug port permanently, no recovery.
// - Level-1 fuse is sampled at reset release, before boot, lockout applied.
// - Level-1 burn needs request pin high throughout; level-0 burn does not.
// - Read-only status bit shows request pin level; pin idles low.
// - Burn value 0xA6 starts the burn; any other value stops it.
// - Setup value 0x54 arms fuse control; other values are reserved.
// - Top bit of security register enables fuse programming when one.
// - Blown fuses are permanent; no write or reset overrides them.
// - Write-enable bit sends data-pointer moves to flash, self-clears per byte.
// - Writes to the write-enable bit are ignored while interrupts are enabled.
// - Mass-erase enable allows exactly one mass erase and must be rewritten.
`timescale 1ns/1ps

module program_security_fuse_control #(
    parameter int BURN_LIMIT_CYCLES = fuse_security_pkg::BURN_CYCLES
) (
    input  wire logic                           clock,
    input  wire logic                           rst,
    // Classic Wishbone slave
    input  wire logic                           wb_cyc_i,
    input  wire logic                           wb_stb_i,
    input  wire logic                           wb_we_i,
    input  wire logic [17:0]                    wb_adr_i,
    input  wire logic [3:0]                     wb_sel_i,
    input  wire logic [31:0]                    wb_dat_i,
    output logic      [31:0]                    wb_dat_o,
    output logic                                wb_ack_o,
    // Core status and flash controller
    input  wire logic                           irq_enabled,
    input  wire logic                           flash_byte_written,
    output logic                                movx_to_flash,
    // Fuse cells
    input  wire logic                           level0_fuse,
    input  wire logic                           level1_fuse,
    output logic      [1:0]                     fuse_burn,
    // External security-request pin
    input  wire logic                           request_pin,
    // Flash requests from processor and debug port
    input  wire fuse_security_pkg::flash_req_t  cpu_req,
    input  wire fuse_security_pkg::flash_req_t  dbg_req,
    output logic                                cpu_grant,
    output logic                                dbg_grant,
    output logic                                dbg_refused,
    output logic                                xram_clear,
    output logic                                debug_port_enable,
    output logic                                level0_active,
    output logic                                burn_overrun
);
    import fuse_security_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {BURN_IDLE, BURN_ARMED, BURN_ACTIVE} burn_state_t;

    burn_state_t state_q;
    burn_state_t state_d;
    logic        ack_q;
    logic [31:0] rdata_q;
    logic        protect_lock_q;
    logic        write_enable_q;
    logic        mass_erase_en_q;
    logic [7:0]  sec_ctl_q;
    logic [1:0]  burn_q;
    logic [1:0]  burn_d;
    logic        lockout_q;
    logic        boot_done_q;
    logic [2:0]  pin_sync_q;
    logic        pin_level_q;
    logic [31:0] burn_cnt_q;
    logic        overrun_q;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire        bus_req      = wb_cyc_i & wb_stb_i & ~ack_q;
    wire [15:0] reg_idx      = wb_adr_i[17:2];
    wire        wr_strobe    = bus_req & wb_we_i & wb_sel_i[0];
    wire [7:0]  wr_byte      = wb_dat_i[7:0];
    wire        hit_flash    = reg_idx == FLASH_CONTROL_IDX;
    wire        hit_burn     = reg_idx == FUSE_BURN_CONTROL_IDX;
    wire        hit_setup    = reg_idx == FUSE_SETUP_CONTROL_IDX;
    wire        hit_status   = reg_idx == SECURITY_FUSE_STATUS_IDX;
    wire        wr_flash     = wr_strobe & hit_flash;
    wire        wr_burn      = wr_strobe & hit_burn;
    wire        wr_setup     = wr_strobe & hit_setup;
    wire        wr_status    = wr_strobe & hit_status;

    // Write-only bits read back as zero
    wire [7:0] flash_rd  = {1'b0, protect_lock_q, 5'b0_0000, write_enable_q};
    wire [7:0] status_rd = {2'b00, pin_level_q, 3'b000, level1_fuse, level0_fuse};
    wire [31:0] rd_word  = hit_flash  ? {24'h00_0000, flash_rd}  :
                           hit_status ? {24'h00_0000, status_rd} :
                           UNMAPPED_READ;

    // ------------------------------------------------------------------
    // Security levels and request gating
    // ------------------------------------------------------------------
    wire level0_on = protect_lock_q & level0_fuse;

    // Decide whether one request may reach the flash array
    function automatic logic allow(input flash_req_t r, input logic from_dbg);
        logic ok;
        ok = r.valid;
        if (r.page_zero && protect_lock_q &&
            (r.op == OP_PAGE_ERASE || r.op == OP_WRITE)) begin
            ok = 1'b0;
        end
        if (r.op == OP_MASS_ERASE && !mass_erase_en_q) begin
            ok = 1'b0;
        end
        if (from_dbg) begin
            if (lockout_q) begin
                ok = 1'b0;
            end
            if (level0_on && r.op != OP_MASS_ERASE) begin
                ok = 1'b0;
            end
            if (protect_lock_q && r.op == OP_READ) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    wire cpu_ok  = allow(cpu_req, 1'b0);
    wire dbg_ok  = allow(dbg_req, 1'b1);
    wire cpu_me  = cpu_ok & (cpu_req.op == OP_MASS_ERASE);
    wire dbg_me  = dbg_ok & (dbg_req.op == OP_MASS_ERASE);
    // Processor wins if both ask for the single armed mass erase
    wire dbg_win = dbg_ok & ~(dbg_me & cpu_me);

    assign cpu_grant         = cpu_ok;
    assign dbg_grant         = dbg_win;
    assign dbg_refused       = dbg_req.valid & ~dbg_win;
    assign xram_clear        = cpu_me | (dbg_me & dbg_win);
    assign level0_active     = level0_on;
    assign debug_port_enable = ~lockout_q;
    assign movx_to_flash     = write_enable_q;
    assign fuse_burn         = burn_q;
    assign wb_ack_o          = ack_q;
    assign wb_dat_o          = rdata_q;
    assign burn_overrun      = overrun_q;

    // ------------------------------------------------------------------
    // Burn sequencer
    // ------------------------------------------------------------------
    wire prog_en    = sec_ctl_q[FUSE_PROGRAM_ENABLE_BIT];
    wire sel0       = sec_ctl_q[LEVEL0_FUSE_BIT];
    wire sel1       = sec_ctl_q[LEVEL1_FUSE_BIT];
    wire one_select = sel0 ^ sel1;
    wire pin_ok     = ~sel1 | pin_level_q;

    always_comb begin
        state_d = state_q;
        burn_d  = burn_q;
        unique case (state_q)
            BURN_IDLE: begin
                if (wr_setup && wr_byte == FUSE_SETUP_VALUE) begin
                    state_d = BURN_ARMED;
                end
            end
            BURN_ARMED: begin
                if (wr_setup && wr_byte != FUSE_SETUP_VALUE) begin
                    state_d = BURN_IDLE;
                end else if (wr_burn && wr_byte == FUSE_BURN_VALUE &&
                             prog_en && one_select && pin_ok) begin
                    state_d = BURN_ACTIVE;
                    burn_d  = {sel1, sel0};
                end
            end
            BURN_ACTIVE: begin
                // A level-1 burn that loses the pin is cut short
                if ((wr_burn && wr_byte != FUSE_BURN_VALUE) || !pin_ok ||
                    !prog_en || wr_setup) begin
                    state_d = BURN_IDLE;
                    burn_d  = 2'b00;
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ack_q   <= 1'b0;
            rdata_q <= UNMAPPED_READ;
        end else begin
            ack_q   <= bus_req;
            rdata_q <= bus_req ? rd_word : rdata_q;
        end
    end

    // ------------------------------------------------------------------
    // Flash control bits
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            protect_lock_q <= 1'b0;
        end else if (wr_flash && wr_byte[PROTECT_LOCK_BIT]) begin
            protect_lock_q <= 1'b1;
        end
    end

    // A fresh set beats the self-clear in the same cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            write_enable_q <= 1'b0;
        end else if (wr_flash && !irq_enabled) begin
            write_enable_q <= wr_byte[PROGRAM_WRITE_ENABLE_BIT];
        end else if (flash_byte_written) begin
            write_enable_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mass_erase_en_q <= 1'b0;
        end else if (wr_flash) begin
            mass_erase_en_q <= wr_byte[MASS_ERASE_ENABLE_BIT];
        end else if (xram_clear) begin
            mass_erase_en_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Security register write side and sequencer state
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sec_ctl_q <= REG_RESET_VALUE;
        end else if (wr_status) begin
            sec_ctl_q <= wr_byte;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= BURN_IDLE;
            burn_q  <= 2'b00;
        end else begin
            state_q <= state_d;
            burn_q  <= burn_d;
        end
    end

    // Software owns the burn time; this only flags an over-long burn
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            burn_cnt_q <= 32'h0000_0000;
            overrun_q  <= 1'b0;
        end else if (state_q != BURN_ACTIVE) begin
            burn_cnt_q <= 32'h0000_0000;
            overrun_q  <= 1'b0;
        end else begin
            burn_cnt_q <= burn_cnt_q + 32'h0000_0001;
            overrun_q  <= burn_cnt_q >= 32'(2 * BURN_LIMIT_CYCLES);
        end
    end

    // ------------------------------------------------------------------
    // Request pin synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_sync_q  <= 3'b000;
            pin_level_q <= 1'b0;
        end else begin
            pin_sync_q <= {pin_sync_q[1:0], request_pin};
            if (pin_sync_q[1] == pin_sync_q[2]) begin
                pin_level_q <= pin_sync_q[2];
            end
        end
    end

    // ------------------------------------------------------------------
    // Level-1 lockout
    // ------------------------------------------------------------------
    // Held locked through reset so nothing leaks before the fuse is read.
    // Fuse state is sensed at reset release and then held sticky in lockout_q, so nothing can undo it.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            boot_done_q <= 1'b0;
            lockout_q   <= 1'b1;
        end else if (!boot_done_q) begin
            boot_done_q <= 1'b1;
            lockout_q   <= level1_fuse;
        end else begin
            lockout_q   <= lockout_q | level1_fuse;
        end
    end

endmodule

// *** sim/program_security_fuse_control_monitor.sv ***
// Concurrent checks on the ports of the security and fuse control block.
// Assumes one clock and the active-high asynchronous reset of the design.
`timescale 1ns/1ps

module program_security_fuse_control_monitor
    import fuse_security_pkg::*;
(
    input wire logic                          clock,
    input wire logic                          rst,
    input wire logic                          wb_cyc_i,
    input wire logic                          wb_stb_i,
    input wire logic                          wb_ack_o,
    input wire fuse_security_pkg::flash_req_t cpu_req,
    input wire fuse_security_pkg::flash_req_t dbg_req,
    input wire logic                          cpu_grant,
    input wire logic                          dbg_grant,
    input wire logic                          xram_clear,
    input wire logic                          debug_port_enable,
    input wire logic                          level0_active,
    input wire logic                          level0_fuse,
    input wire logic                          level1_fuse,
    input wire logic [1:0]                    fuse_burn
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------------
    // Bus handshake and gating
    // ------------------------------------------------------------------
    property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held too long");
    property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack not one cycle later");
    property p_l0_fuse; level0_active |-> level0_fuse; endproperty
    a_l0_fuse: assert property (p_l0_fuse) else $error("level 0 without fuse");
    property p_l0_dbg;
        level0_active && dbg_req.valid && dbg_req.op != OP_MASS_ERASE |-> !dbg_grant;
    endproperty
    a_l0_dbg: assert property (p_l0_dbg) else $error("debug op under level 0");
    property p_pz_wr;
        level0_active && cpu_req.valid && cpu_req.op == OP_WRITE && cpu_req.page_zero
            |-> !cpu_grant;
    endproperty
    a_pz_wr: assert property (p_pz_wr) else $error("page zero write granted");
    property p_xram;
        xram_clear |-> (cpu_grant && cpu_req.op == OP_MASS_ERASE)
            || (dbg_grant && dbg_req.op == OP_MASS_ERASE);
    endproperty
    a_xram: assert property (p_xram) else $error("xram clear without erase");
    property p_lock; !debug_port_enable |-> !dbg_grant; endproperty
    a_lock: assert property (p_lock) else $error("grant while port locked");
    property p_l1; level1_fuse |=> !debug_port_enable; endproperty
    a_l1: assert property (p_l1) else $error("port open with level 1 fuse");
    property p_one_sel; $onehot0(fuse_burn); endproperty
    a_one_sel: assert property (p_one_sel) else $error("two fuses burning");
endmodule

// *** sim/fuse_cell_model.sv ***
// Behavioural pair of security fuse cells driven by the burn outputs.
// Assumes a cell opens after BLOW_CYCLES of continuous burn current.
`timescale 1ns/1ps

module fuse_cell_model #(
    parameter int BLOW_CYCLES = 8
) (
    input  wire logic [1:0] fuse_burn,
    input  wire logic       clock,
    output logic            level0_fuse = 1'b0,
    output logic            level1_fuse = 1'b0
);
    int c0 = 0;
    int c1 = 0;
    // No reset input: a blown cell never heals
    always @(posedge clock) begin
        c0 <= fuse_burn[0] ? c0 + 1 : 0;
        c1 <= fuse_burn[1] ? c1 + 1 : 0;
        if (c0 >= BLOW_CYCLES) level0_fuse <= 1'b1;
        if (c1 >= BLOW_CYCLES) level1_fuse <= 1'b1;
    end
endmodule

// *** sim/program_security_fuse_control_tb.sv ***
// Self-checking bench: Wishbone register tasks, flash request gating, fuse burns.
// Assumes the fuse cell model and a burn limit shortened for simulation.
`timescale 1ns/1ps

module program_security_fuse_control_tb;
    import fuse_security_pkg::*;
    logic        clock = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic        irq = 1'b0, fbw = 1'b0, pin = 1'b0;
    logic [17:0] adr = 18'h0_0000;
    logic [31:0] dat = 32'h0000_0000, rdat, q;
    logic        ack, movx, dpe, l0a, cg, dg, drf, xc, f0, f1, ovr;
    logic [1:0]  burn;
    flash_req_t  cpu = '0, dbg = '0;
    int          n_errors = 0, compares = 0, cyc_n = 0;

    always #20 clock = ~clock;

    program_security_fuse_control #(.BURN_LIMIT_CYCLES(10)) i_program_security_fuse_control (
        .clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .irq_enabled(irq), .flash_byte_written(fbw), .movx_to_flash(movx),
        .level0_fuse(f0), .level1_fuse(f1), .fuse_burn(burn), .request_pin(pin),
        .cpu_req(cpu), .dbg_req(dbg), .cpu_grant(cg), .dbg_grant(dg), .dbg_refused(drf),
        .xram_clear(xc), .debug_port_enable(dpe), .level0_active(l0a), .burn_overrun(ovr));
    fuse_cell_model i_fuse_cell_model (
        .fuse_burn(burn), .clock(clock), .level0_fuse(f0), .level1_fuse(f1));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic final_report;
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic bus(input logic [15:0] i, input logic w, input logic [7:0] d);
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        dat <= {24'h00_0000, d};
        @(posedge clock);
        while (ack !== 1'b1) @(posedge clock);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [15:0] i, input logic [7:0] d);
        bus(i, 1'b1, d);
    endtask
    task automatic rd(input string nm, input logic [15:0] i, input logic [7:0] e);
        bus(i, 1'b0, 8'h00);
        chk(nm, q, {24'h00_0000, e});
    endtask
    task automatic burn_seq(input logic [7:0] s);
        wr(FUSE_SETUP_CONTROL_IDX, FUSE_SETUP_VALUE);
        wr(SECURITY_FUSE_STATUS_IDX, s);
        wr(FUSE_BURN_CONTROL_IDX, FUSE_BURN_VALUE);
    endtask
    // Requests change at an edge; grants are looked at once they settle
    task automatic req(input flash_req_t c, input flash_req_t d);
        @(posedge clock);
        cpu <= c;
        dbg <= d;
        #1;
    endtask
    function automatic flash_req_t rq(input flash_op_t o, input logic p);
        return '{1'b1, o, p};
    endfunction
    task automatic do_reset;
        @(posedge clock);
        rst <= 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
    endtask

    always @(posedge clock) begin
        cyc_n++;
        if (cyc_n == 3000) begin
            n_errors++;
            final_report;
        end
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        do_reset;
        chk("debug port", dpe, 1'b1);
        rd("flash_control", FLASH_CONTROL_IDX, 8'h00);
        rd("unmapped", 16'h0123, 8'h00);
        pin <= 1'b1;
        repeat (5) @(posedge clock);
        rd("pin level", SECURITY_FUSE_STATUS_IDX, 8'h20);
        pin <= 1'b0;
        $display("test reset and status done");
        wr(FLASH_CONTROL_IDX, 8'h40);
        wr(FLASH_CONTROL_IDX, 8'h00);
        rd("lock kept", FLASH_CONTROL_IDX, 8'h40);
        chk("level0 off", l0a, 1'b0);
        req(rq(OP_WRITE, 1'b1), rq(OP_READ, 1'b0));
        chk("page zero write", cg, 1'b0);
        chk("debug read", drf, 1'b1);
        req(rq(OP_PAGE_ERASE, 1'b1), rq(OP_WRITE, 1'b1));
        chk("page zero erase", cg, 1'b0);
        chk("debug page zero write", dg, 1'b0);
        req(rq(OP_WRITE, 1'b0), rq(OP_MASS_ERASE, 1'b0));
        chk("other page write", cg, 1'b1);
        chk("erase no enable", dg, 1'b0);
        // Drop the pending erase so arming does not consume it at once
        req('0, '0);
        wr(FLASH_CONTROL_IDX, 8'h02);
        req('0, rq(OP_MASS_ERASE, 1'b0));
        chk("erase", dg, 1'b1);
        chk("xram clear", xc, 1'b1);
        req('0, rq(OP_MASS_ERASE, 1'b0));
        chk("erase reused", dg, 1'b0);
        req('0, '0);
        $display("test lock and erase done");
        @(posedge clock);
        irq <= 1'b1;
        wr(FLASH_CONTROL_IDX, 8'h41);
        chk("write enable blocked", movx, 1'b0);
        irq <= 1'b0;
        wr(FLASH_CONTROL_IDX, 8'h41);
        chk("write enable", movx, 1'b1);
        fbw <= 1'b1;
        @(posedge clock);
        fbw <= 1'b0;
        @(posedge clock);
        chk("write enable self clear", movx, 1'b0);
        do_reset;
        rd("lock cleared", FLASH_CONTROL_IDX, 8'h00);
        $display("test write enable done");
        wr(FUSE_SETUP_CONTROL_IDX, 8'h13);
        wr(SECURITY_FUSE_STATUS_IDX, SELECT_LEVEL0);
        wr(FUSE_BURN_CONTROL_IDX, FUSE_BURN_VALUE);
        chk("burn not armed", burn, 2'b00);
        burn_seq(8'h01);
        chk("burn no program enable", burn, 2'b00);
        burn_seq(SELECT_LEVEL0);
        chk("burn level0", burn, 2'b01);
        repeat (12) @(posedge clock);
        wr(FUSE_BURN_CONTROL_IDX, 8'h00);
        chk("burn stop", burn, 2'b00);
        rd("level0 blown", SECURITY_FUSE_STATUS_IDX, 8'h01);
        wr(FLASH_CONTROL_IDX, 8'h42);
        chk("level0 on", l0a, 1'b1);
        req(rq(OP_WRITE, 1'b1), rq(OP_READ, 1'b0));
        chk("level0 page zero write", cg, 1'b0);
        chk("level0 debug read", dg, 1'b0);
        req('0, rq(OP_MASS_ERASE, 1'b0));
        chk("level0 debug erase", dg, 1'b1);
        req('0, '0);
        do_reset;
        rd("fuse kept", SECURITY_FUSE_STATUS_IDX, 8'h01);
        chk("level0 left", l0a, 1'b0);
        req('0, rq(OP_READ, 1'b0));
        chk("debug back", dg, 1'b1);
        req('0, '0);
        $display("test level0 done");
        burn_seq(SELECT_LEVEL1);
        chk("level1 pin low", burn, 2'b00);
        pin <= 1'b1;
        repeat (5) @(posedge clock);
        burn_seq(SELECT_LEVEL1);
        chk("burn level1", burn, 2'b10);
        repeat (12) @(posedge clock);
        chk("port disabled", dpe, 1'b0);
        chk("no overrun yet", ovr, 1'b0);
        repeat (10) @(posedge clock);
        chk("burn overrun", ovr, 1'b1);
        wr(FUSE_BURN_CONTROL_IDX, 8'h00);
        do_reset;
        chk("port stays off", dpe, 1'b0);
        req('0, rq(OP_READ, 1'b0));
        chk("locked debug read", dg, 1'b0);
        req('0, '0);
        $display("test level1 done");
        final_report;
    end
endmodule

bind program_security_fuse_control program_security_fuse_control_monitor
    i_program_security_fuse_control_monitor (
    .clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .cpu_req(cpu_req), .dbg_req(dbg_req), .cpu_grant(cpu_grant), .dbg_grant(dbg_grant),
    .xram_clear(xram_clear), .debug_port_enable(debug_port_enable),
    .level0_active(level0_active), .level0_fuse(level0_fuse), .level1_fuse(level1_fuse),
    .fuse_burn(fuse_burn));
